// ---- sine_pwm_pkg.sv ----
// Shared constants for the three-phase sine PWM generator.
package sine_pwm_pkg;
  localparam int DUTY_W = 8;
  localparam int SCALE_W = 8;
  localparam int DIV_SHIFT = 8;
  localparam int PHASES = 3;
  localparam int STEPS = 192;
  localparam int ENTRIES = STEPS * PHASES;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int SHIFT_120 = 64;
  localparam int SEGMENT = 64;
  localparam int STEP_DEG_X8 = 15;
  localparam int HALF_TURN_X8 = 1440;
  localparam int BHASKARA_K = 2592000;
  localparam int PWM_PERIOD = 510;
  localparam logic [7:0] CNT_TOP = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_PRELOAD = 8'h00;
  localparam logic [7:0] DUTY_MAX = 8'hFF;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [1:0] LAST_ENTRY = 2'h3;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_READ = 2'b01,
    SEQ_SPARE = 2'b11
  } seq_state_t;
endpackage

// ---- pwm_link_if.sv ----
// Link between the compare sequencer and one PWM counter channel.
`timescale 1ns/1ps
interface pwm_link_if;
  logic [7:0] hi_cmp;
  logic [7:0] lo_cmp;
  logic at_bottom;
  logic hi_out;
  logic lo_out;
  modport ctrl (output hi_cmp, output lo_cmp, input at_bottom, input hi_out, input lo_out);
  modport chan (input hi_cmp, input lo_cmp, output at_bottom, output hi_out, output lo_out);
endinterface

// ---- wave_table_rom.sv ----
// Interleaved waveform table with a registered read port.
`timescale 1ns/1ps
module wave_table_rom
  import sine_pwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [ADDR_W-1:0] addr,
  output logic [DUTY_W-1:0] rd_data
);
  typedef logic [7:0] rom_t [ENTRIES];
  typedef struct packed {
    logic [7:0] rd;
  } rom_state_t;

  // hump shapes give sine line voltages.
  // Terminal shape: rising sine, mirrored sine, then zero for a third of the turn.
  function automatic logic [7:0] shape(input int pos);
    int a;
    int p;
    int v;
    a = 0;
    if (pos < SEGMENT) begin
      a = pos * STEP_DEG_X8;
    end else if (pos < 2 * SEGMENT) begin
      a = (2 * SEGMENT - pos) * STEP_DEG_X8;
    end
    p = a * (HALF_TURN_X8 - a);
    v = (255 * 4 * p) / (BHASKARA_K - p);
    if (pos >= 2 * SEGMENT) begin
      v = 0;
    end
    return v[7:0];
  endfunction

  function automatic rom_t build();
    rom_t t;
    for (int i = 0; i < ENTRIES; i++) begin
      t[i] = shape(((i / PHASES) + STEPS - (i % PHASES) * SHIFT_120) % STEPS);
    end
    return t;
  endfunction

  localparam rom_t TABLE = build();

  rom_state_t s_q;
  rom_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rd = (int'(addr) < ENTRIES) ? TABLE[addr] : 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign rd_data = s_q.rd;
endmodule

// ---- pwm_channel.sv ----
// One dual-slope PWM counter driving a half-bridge switch pair.
`timescale 1ns/1ps
module pwm_channel
  import sine_pwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  pwm_link_if.chan link
);
  typedef struct packed {
    logic [7:0] cnt;
    logic down;
    logic [7:0] hi_act;
    logic [7:0] lo_act;
    logic bottom;
    logic hi;
    logic lo;
  } chan_state_t;

  chan_state_t s_q;
  chan_state_t s_d;

  always_comb begin
    s_d = s_q;
    // count up to top and back to zero.
    if (!s_q.down) begin
      s_d.cnt = s_q.cnt + 8'h01;
      s_d.down = (s_d.cnt == CNT_TOP);
    end else begin
      s_d.cnt = s_q.cnt - 8'h01;
      s_d.down = (s_d.cnt != CNT_BOTTOM);
    end
    // both compares load together at top.
    if (s_d.cnt == CNT_TOP) begin
      s_d.hi_act = link.hi_cmp;
      s_d.lo_act = link.lo_cmp;
    end
    s_d.bottom = (s_d.cnt == CNT_BOTTOM);
    // high clears on up-match, low sets on up-match.
    s_d.hi = (s_d.cnt < s_d.hi_act);
    s_d.lo = (s_d.cnt >= s_d.lo_act);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // every counter starts from the same preload.
      s_q <= '{cnt: CNT_PRELOAD, down: 1'b0, hi_act: CMP_RESET, lo_act: CMP_RESET,
               bottom: 1'b0, hi: 1'b0, lo: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.at_bottom = s_q.bottom;
  assign link.hi_out = s_q.hi;
  assign link.lo_out = s_q.lo;
endmodule

// ---- three_phase_sine_pwm.sv ----
// Three-phase sine PWM generator: table fetch, scaling, dead-time and three counters.
// What this block does
// - Three independent PWM counters, each driving one half-bridge switch pair.
// - All three counters preloaded alike so they run in lock-step.
// - Compare values come from fetch, then scaling, then dead-time adjustment.
// - Scaled duty is table value times amplitude, shifted right by the exponent.
// - Table and scale are 8 bits, exponent 8, giving an 8-bit duty.
// - Fetch, scale and dead-time are redone for all channels every PWM cycle.
// - Forward driving follows the forward terminal pattern per step pair.
// - Reverse driving follows the reverse terminal pattern per step pair.
// - Patterns give three sine line-to-line voltages 120 degrees apart.
// - Each terminal holds zero duty for one third of each revolution.
// - Table interleaves base, minus 120 and minus 240 values per position.
// - Consecutive entries go to U, V, W forward and U, W, V reverse.
// - Counters run up and down between 0 and 255, period 510 clocks.
// - High side clears on up-match, low side sets on up-match.
// - High compare is duty minus half dead-time, low compare duty plus it.
// - Both compare values of a channel take effect at the same instant.
`timescale 1ns/1ps
module three_phase_sine_pwm
  import sine_pwm_pkg::*;
#(
  parameter int DUTY_BITS = DUTY_W
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [sine_pwm_pkg::IDX_W-1:0] table_index,
  input wire logic reverse_dir,
  input wire logic [sine_pwm_pkg::SCALE_W-1:0] amplitude,
  input wire logic [sine_pwm_pkg::DUTY_W-1:0] dead_half,
  output logic [2:0] high_side_drive,
  output logic [2:0] low_side_drive,
  output logic cycle_tick
);
  import sine_pwm_pkg::*;

  if (DUTY_BITS != SCALE_W + DUTY_W - DIV_SHIFT) begin : g_bad_width
    $error("Duty width must equal scale width plus table width minus the shift.");
  end

  typedef struct packed {
    seq_state_t st;
    logic [1:0] k;
    logic [IDX_W-1:0] idx;
    logic rev;
    logic [SCALE_W-1:0] amp;
    logic [DUTY_W-1:0] half;
    logic [2:0][7:0] hi_cmp;
    logic [2:0][7:0] lo_cmp;
    logic tick;
  } seq_t;

  seq_t s_q;
  seq_t s_d;
  logic [ADDR_W-1:0] rom_addr;
  logic [DUTY_W-1:0] rom_data;
  logic [2:0] bottom;
  logic [15:0] product;
  logic [7:0] duty;
  logic [8:0] lo_sum;
  logic [1:0] ch;

  pwm_link_if link [PHASES] ();

  for (genvar g = 0; g < PHASES; g++) begin : g_chan
    pwm_channel u_chan (
      .ref_clk(ref_clk),
      .reset(reset),
      .link(link[g].chan)
    );
    assign link[g].hi_cmp = s_q.hi_cmp[g];
    assign link[g].lo_cmp = s_q.lo_cmp[g];
    assign bottom[g] = link[g].at_bottom;
    assign high_side_drive[g] = link[g].hi_out;
    assign low_side_drive[g] = link[g].lo_out;
  end

  // the three entries of a position are read in sequence.
  assign rom_addr = ADDR_W'(s_q.idx) * ADDR_W'(PHASES) + ADDR_W'(s_q.k);

  wave_table_rom u_rom (
    .ref_clk(ref_clk),
    .addr(rom_addr),
    .rd_data(rom_data)
  );

  // Counters share reset and preload, so channel 0 stands for all three.
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // multiply, then divide by two to the shift.
    // eight by eight bits, shift of eight.
    product = rom_data * s_q.amp;
    duty = product[DIV_SHIFT +: DUTY_W];
    lo_sum = {1'b0, duty} + {1'b0, s_q.half};
    // entry order U,V,W forward and U,W,V reverse.
    // forward pattern from forward read order.
    // reverse pattern from swapped read order.
    ch = 2'(s_q.k - 2'h1);
    if (s_q.rev && ch != 2'h0) begin
      ch = 2'h3 - ch;
    end
    case (s_q.st)
      SEQ_IDLE: begin
        if (bottom[0]) begin
          s_d.idx = (int'(table_index) < STEPS) ? table_index : IDX_W'(0);
          s_d.rev = reverse_dir;
          s_d.amp = amplitude;
          s_d.half = dead_half;
          s_d.k = 2'h0;
          s_d.st = SEQ_READ;
          s_d.tick = 1'b1;
        end
      end
      SEQ_READ: begin
        // fetch, scale, then dead-time in order.
        if (s_q.k != 2'h0) begin
          // split the dead-time around the duty.
          s_d.hi_cmp[ch] = (duty > s_q.half) ? duty - s_q.half : 8'h00;
          s_d.lo_cmp[ch] = lo_sum[8] ? DUTY_MAX : lo_sum[7:0];
        end
        s_d.k = s_q.k + 2'h1;
        if (s_q.k == LAST_ENTRY) begin
          s_d.st = SEQ_IDLE;
        end
      end
      default: begin
        s_d.st = SEQ_IDLE;
      end
    endcase
  end

  // The shadow compares change well before top, so a channel never loads a half-written pair.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '{st: SEQ_IDLE, k: 2'h0, idx: '0, rev: 1'b0, amp: '0, half: '0,
               hi_cmp: '0, lo_cmp: '0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cycle_tick = s_q.tick;
endmodule

// ---- sine_pwm_properties.sv ----
// Concurrent checks on the ports of the three-phase sine PWM block.
`timescale 1ns/1ps
module sine_pwm_properties #(parameter int DUTY_BITS = 8) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] table_index,
  input wire logic reverse_dir,
  input wire logic [7:0] amplitude,
  input wire logic [7:0] dead_half,
  input wire logic [2:0] high_side_drive,
  input wire logic [2:0] low_side_drive,
  input wire logic cycle_tick
);
  logic [9:0] since_q;
  logic seen_q;
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge ref_clk) begin
    hi_q <= high_side_drive;
    lo_q <= low_side_drive;
    if (reset) begin
      since_q <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      since_q <= cycle_tick ? 10'h000 : since_q + 10'h001;
      seen_q <= seen_q | cycle_tick;
    end
  end
  sequence tick_s;
    cycle_tick ##1 !cycle_tick [*8];
  endsequence
  no_overlap_a: assert property ((high_side_drive & low_side_drive) == 3'h0)
    else $error("both switches on");
  tick_pulse_a: assert property (cycle_tick |-> tick_s)
    else $error("tick too long");
  tick_period_a: assert property (seen_q && cycle_tick |-> since_q == 10'h1FD)
    else $error("tick period wrong");
  reset_quiet_a:
    assert property (disable iff (1'b0)
      reset |=> !cycle_tick && (high_side_drive | low_side_drive) == 3'h0)
    else $error("drive on after reset");
  high_up_a: assert property (|(hi_q & ~high_side_drive) |-> since_q < 10'h104)
    else $error("high side cleared off the up slope");
  low_up_a: assert property (|(~lo_q & low_side_drive) |-> since_q < 10'h104)
    else $error("low side set off the up slope");
  high_down_a: assert property (|(~hi_q & high_side_drive) |-> ##[1:260] cycle_tick)
    else $error("high side set off the down slope");
  low_down_a: assert property (|(lo_q & ~low_side_drive) |-> ##[1:260] cycle_tick)
    else $error("low side cleared off the down slope");
  dead_gap_a:
    assert property (dead_half != 8'h00 |-> (hi_q & ~high_side_drive & low_side_drive) == 3'h0)
    else $error("no dead time after high side off");
endmodule
bind three_phase_sine_pwm sine_pwm_properties #(.DUTY_BITS(DUTY_BITS)) chk_u (
  .ref_clk(ref_clk), .reset(reset), .table_index(table_index), .reverse_dir(reverse_dir),
  .amplitude(amplitude), .dead_half(dead_half), .high_side_drive(high_side_drive),
  .low_side_drive(low_side_drive), .cycle_tick(cycle_tick));

// ---- half_bridge_stage.sv ----
// Behavioural model of the three half-bridges that the drive outputs switch.
`timescale 1ns/1ps
module half_bridge_stage (
  input wire logic ref_clk,
  input wire logic [2:0] high_side_drive,
  input wire logic [2:0] low_side_drive,
  output logic [2:0] terminal,
  output logic [2:0] floating,
  output logic shoot_through
);
  logic shoot_q = 1'b0;
  // A released terminal flips, so a stale level is never taken for a drive.
  always_ff @(posedge ref_clk) begin
    terminal <= high_side_drive | ~(low_side_drive | terminal);
    if ((high_side_drive & low_side_drive) != 3'h0) begin
      shoot_q <= 1'b1;
    end
  end
  assign floating = ~(high_side_drive | low_side_drive);
  assign shoot_through = shoot_q;
endmodule

// ---- test_three_phase_sine_pwm.sv ----
// Self-checking bench for the three-phase sine PWM generator.
`timescale 1ns/1ps
module test_three_phase_sine_pwm;
  import sine_pwm_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic rev;
    logic [7:0] amp;
    logic [7:0] dh;
    logic [2:0] z;
  } row_t;
  // Index, reverse, amplitude, half dead-time and the terminals held at zero duty.
  row_t rows [8] = '{'{8'h20, 1'b0, 8'h80, 8'h04, 3'h2}, '{8'h20, 1'b1, 8'h80, 8'h04, 3'h4},
    '{8'h60, 1'b0, 8'h80, 8'h03, 3'h4}, '{8'h60, 1'b1, 8'h80, 8'h03, 3'h2},
    '{8'hA0, 1'b0, 8'h80, 8'h05, 3'h1}, '{8'hA0, 1'b1, 8'h80, 8'h05, 3'h1},
    '{8'hC8, 1'b0, 8'h80, 8'h02, 3'h3}, '{8'h20, 1'b0, 8'h00, 8'h06, 3'h7}};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reverse_dir = 1'b0;
  logic [7:0] table_index = 8'h00, amplitude = 8'h00, dead_half = 8'h02;
  logic [2:0] high_side_drive, low_side_drive, floating;
  logic cycle_tick, shoot_through;
  logic [15:0] hi_n [3];
  logic [15:0] off_n [3];
  int miscompares = 0, checks_done = 0, n_wait;
  always #4 ref_clk = ~ref_clk;
  three_phase_sine_pwm #(.DUTY_BITS(DUTY_W)) dut_u (.ref_clk(ref_clk), .reset(reset),
    .table_index(table_index), .reverse_dir(reverse_dir), .amplitude(amplitude),
    .dead_half(dead_half), .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .cycle_tick(cycle_tick));
  half_bridge_stage hb_u (.ref_clk(ref_clk), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .terminal(), .floating(floating),
    .shoot_through(shoot_through));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_tick();
    n_wait = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n_wait++;
    end while (cycle_tick !== 1'b1 && n_wait < 600);
    // A missing tick is a hang, so it counts as a mismatch.
    if (cycle_tick !== 1'b1) begin
      check(16'(cycle_tick), 16'h0001);
    end
  endtask
  task automatic end_sim();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    foreach (rows[r]) begin
      {table_index, reverse_dir} = {rows[r].idx, rows[r].rev};
      {amplitude, dead_half} = {rows[r].amp, rows[r].dh};
      wait_tick();
      // Changes between samples must not reach the compares.
      amplitude = 8'h00;
      table_index = 8'hC0;
      repeat (257) @(posedge ref_clk);
      for (int p = 0; p < 3; p++) begin
        hi_n[p] = 16'h0000;
        off_n[p] = 16'h0000;
      end
      repeat (510) begin
        @(posedge ref_clk);
        #1;
        for (int p = 0; p < 3; p++) begin
          hi_n[p] += 16'(high_side_drive[p]);
          off_n[p] += 16'(floating[p]);
        end
      end
      for (int p = 0; p < 3; p++) begin
        check(16'(hi_n[p] == 16'h0000), 16'(rows[r].z[p]));
        check(off_n[p], 16'(rows[r].z[p] ? 2 * rows[r].dh - 1 : 4 * rows[r].dh));
      end
      $display("row %0d done", r);
    end
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(16'({high_side_drive, low_side_drive, cycle_tick}), 16'h0000);
    reset = 1'b0;
    wait_tick();
    check(16'(n_wait > 500 && n_wait < 520), 16'h0001);
    wait_tick();
    check(16'(n_wait), 16'h01FE);
    check(16'(shoot_through), 16'h0000);
    $display("reset and period test done");
    end_sim();
  end
endmodule
